// ---- hpsh_top.v ----
// Strobe handshake of the 8-bit parallel host port, device side.
// Assumes host pins are resolved outside from out and enable signals,
// and that the core supplies read data, vector and service requests.
`timescale 1ns/10ps
`include "hpsh_map.vh"
module hpsh_top #(
    parameter DATA_W = `HPSH_DATA_W,
    parameter SEL_W  = `HPSH_SEL_W,
    parameter DEPTH  = `HPSH_FIFO_DEPTH,
    parameter AW     = `HPSH_FIFO_AW
) (
    input  wire              clock,         // System clock, 10 MHz
    input  wire              arst_n,        // Asynchronous reset, active low
    // Host side pins
    input  wire              strobePinIn,   // Transfer strobe pin level
    output reg               strobePinOut,  // Strobe pin GPIO drive value
    output reg               strobePinOe,   // Strobe pin GPIO drive enable
    input  wire              host_direction,// High: host reads
    input  wire [SEL_W-1:0]  host_reg_select,// Register select
    input  wire [DATA_W-1:0] dataPinIn,     // Data bus level
    output reg  [DATA_W-1:0] dataPinOut,    // Data bus drive value
    output reg  [DATA_W-1:0] dataPinOe,     // Data bus drive enable
    input  wire              reqPinIn,      // Request pin level
    output reg               reqPinOut,     // Request pin drive value
    output reg               reqPinOe,      // Request pin drive enable
    input  wire              ackPinIn,      // Acknowledge pin level
    output reg               ackPinOut,     // Acknowledge pin drive value
    output reg               ackPinOe,      // Acknowledge pin drive enable
    // Core side
    input  wire              hostPortSelect,// Host function selected
    input  wire              ackAsGpio,     // Acknowledge pin kept GPIO
    input  wire [2:0]        gpioOutValue,  // GPIO drive values
    input  wire [2:0]        gpioOutDir,    // GPIO directions, high out
    output reg  [2:0]        gpioInValue,   // Synchronised pin levels
    input  wire              serviceReq,    // Core wants host service
    input  wire              irqMode,       // Request is an interrupt
    input  wire [DATA_W-1:0] coreReadData,  // Data for host reads
    input  wire [DATA_W-1:0] coreVector,    // Interrupt vector
    output reg               readDonePulse, // Host read finished
    output reg  [SEL_W-1:0]  readSelect,    // Register of last strobed access, read or write
    output reg               dmaAckPulse,   // DMA handshake seen
    output reg               intAckPulse,   // Interrupt acknowledge seen
    output reg               writeOverflow, // Write lost, buffer full
    output wire              wrValid,       // Buffered write valid
    input  wire              wrReady,       // Core takes buffered write
    output wire [DATA_W-1:0] wrData,        // Buffered write data
    output wire [SEL_W-1:0]  wrSelect       // Buffered write register
);

    // ----------------------------------------------------------------
    // Reset release and input synchronisers
    // ----------------------------------------------------------------
    reg              rstMeta_reg;
    reg              rst_n_reg;
    reg              strobeMeta_reg;
    reg              strobeSync_reg;
    reg              strobePrev_reg;
    reg              ackMeta_reg;
    reg              ackSync_reg;
    reg              ackPrev_reg;
    reg              dirMeta_reg;
    reg              dirSync_reg;
    reg [SEL_W-1:0]  selMeta_reg;
    reg [SEL_W-1:0]  selSync_reg;
    reg [DATA_W-1:0] dataMeta_reg;
    reg [DATA_W-1:0] dataSync_reg;
    reg [2:0]        gpioMeta_reg;
    reg              selectMode_reg;
    reg              ackGpio_reg;
    reg              reqAssert_reg;
    reg              strobeRead_reg;
    reg [DATA_W-1:0] wrHold_reg;
    reg [SEL_W-1:0]  selHold_reg;
    reg              pushValid_reg;
    reg [`HPSH_WORD_W-1:0] pushWord_reg;
    wire             strobeRise;
    wire             ackFall;
    wire             ackActive;
    wire             ackCycle;
    wire             inReady;
    wire [`HPSH_WORD_W-1:0] popWord;

    // Reset release through two flip-flops
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_reg <= 1'b0;
            rst_n_reg   <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rst_n_reg   <= rstMeta_reg;
        end
    end

    // Two-stage synchronisers on every host pin
    always @(posedge clock) begin
        if (!rst_n_reg) begin
            strobeMeta_reg <= 1'b1;
            strobeSync_reg <= 1'b1;
            ackMeta_reg    <= 1'b1;
            ackSync_reg    <= 1'b1;
            dirMeta_reg    <= 1'b0;
            dirSync_reg    <= 1'b0;
            selMeta_reg    <= {SEL_W{1'b0}};
            selSync_reg    <= {SEL_W{1'b0}};
            dataMeta_reg   <= `HPSH_RST_BYTE;
            dataSync_reg   <= `HPSH_RST_BYTE;
            gpioMeta_reg   <= `HPSH_RST_LINES;
            gpioInValue    <= `HPSH_RST_LINES;
        end else begin
            strobeMeta_reg <= strobePinIn;
            strobeSync_reg <= strobeMeta_reg; // RULE14
            ackMeta_reg    <= ackPinIn;
            ackSync_reg    <= ackMeta_reg;
            dirMeta_reg    <= host_direction;
            dirSync_reg    <= dirMeta_reg;
            selMeta_reg    <= host_reg_select;
            selSync_reg    <= selMeta_reg; // RULE13
            dataMeta_reg   <= dataPinIn;
            dataSync_reg   <= dataMeta_reg;
            gpioMeta_reg   <= {ackPinIn, reqPinIn, strobePinIn};
            gpioInValue    <= gpioMeta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Strobe and acknowledge edge detection
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n_reg) begin
            strobePrev_reg <= 1'b1;
            ackPrev_reg    <= 1'b1;
            selectMode_reg <= 1'b0;
            ackGpio_reg    <= 1'b0;
            reqAssert_reg  <= 1'b0;
        end else begin
            strobePrev_reg <= strobeSync_reg;
            ackPrev_reg    <= ackSync_reg;
            selectMode_reg <= hostPortSelect;
            ackGpio_reg    <= ackAsGpio;
            reqAssert_reg  <= serviceReq && inReady;
        end
    end

    // Rising strobe ends an access; falling acknowledge opens a cycle
    assign strobeRise = selectMode_reg && strobeSync_reg && !strobePrev_reg; // RULE14
    assign ackActive  = selectMode_reg && !ackGpio_reg;
    assign ackFall    = ackActive && !ackSync_reg && ackPrev_reg;
    assign ackCycle   = ackActive && !ackSync_reg && reqAssert_reg;

    // ----------------------------------------------------------------
    // Host write capture into the buffer
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n_reg) begin
            wrHold_reg     <= `HPSH_RST_BYTE;
            selHold_reg    <= {SEL_W{1'b0}};
            strobeRead_reg <= 1'b0;
            pushValid_reg  <= 1'b0;
            pushWord_reg   <= {`HPSH_WORD_W{1'b0}};
            writeOverflow  <= 1'b0;
        end else begin
            // Last sample before the rising edge is the written byte
            if (selectMode_reg && !strobeSync_reg) begin
                wrHold_reg     <= dataSync_reg; // RULE2
                selHold_reg    <= selSync_reg;
                strobeRead_reg <= dirSync_reg;
            end
            pushValid_reg <= 1'b0;
            writeOverflow <= 1'b0;
            if (strobeRise && !strobeRead_reg) begin
                pushWord_reg  <= {selHold_reg, wrHold_reg}; // RULE3
                pushValid_reg <= inReady;
                writeOverflow <= !inReady;
            end
        end
    end

    // Write buffer; request is withheld while it is full
    hpsh_fifo #(
        .WIDTH    (`HPSH_WORD_W),
        .DEPTH    (DEPTH),
        .AW       (AW)
    ) u_fifo (
        .clock    (clock),
        .rst_n    (rst_n_reg),
        .inValid  (pushValid_reg),
        .inReady  (inReady),
        .inData   (pushWord_reg),
        .outValid (wrValid),
        .outReady (wrReady),
        .outData  (popWord)
    );

    assign wrData   = popWord[`HPSH_WORD_SEL_LSB-1:`HPSH_WORD_DATA_LSB];
    assign wrSelect = popWord[`HPSH_WORD_W-1:`HPSH_WORD_SEL_LSB];

    // ----------------------------------------------------------------
    // Host read, acknowledge and data bus drive
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n_reg) begin
            dataPinOut    <= `HPSH_RST_BYTE;
            dataPinOe     <= {DATA_W{1'b0}};
            readDonePulse <= 1'b0;
            readSelect    <= {SEL_W{1'b0}};
            dmaAckPulse   <= 1'b0;
            intAckPulse   <= 1'b0;
        end else begin
            if (ackCycle) begin
                dataPinOut <= irqMode ? coreVector : coreReadData; // RULE7
                dataPinOe  <= {DATA_W{1'b1}};
            end else if (selectMode_reg && !strobeSync_reg && dirSync_reg) begin
                dataPinOut <= coreReadData; // RULE1
                dataPinOe  <= {DATA_W{1'b1}};
            end else begin
                dataPinOe  <= {DATA_W{1'b0}}; // RULE12
            end
            readDonePulse <= strobeRise && strobeRead_reg;
            if (strobeRise)
                readSelect <= selHold_reg; // RULE13
            dmaAckPulse <= ackFall && reqAssert_reg && !irqMode; // RULE6
            intAckPulse <= ackFall && reqAssert_reg && irqMode;  // RULE7
        end
    end

    // ----------------------------------------------------------------
    // Shared pin function: host port or GPIO
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n_reg) begin
            strobePinOut <= 1'b0; // RULE11
            strobePinOe  <= 1'b0;
            reqPinOut    <= 1'b0;
            reqPinOe     <= 1'b0;
            ackPinOut    <= 1'b0;
            ackPinOe     <= 1'b0;
        end else begin
            // Strobe pin is only an input in host mode
            strobePinOut <= gpioOutValue[`HPSH_LINE_STROBE];
            strobePinOe  <= !selectMode_reg && gpioOutDir[`HPSH_LINE_STROBE]; // RULE8
            if (selectMode_reg) begin
                reqPinOut <= 1'b0;
                reqPinOe  <= reqAssert_reg; // RULE5
            end else begin
                reqPinOut <= gpioOutValue[`HPSH_LINE_REQ];
                reqPinOe  <= gpioOutDir[`HPSH_LINE_REQ]; // RULE9
            end
            ackPinOut <= gpioOutValue[`HPSH_LINE_ACK];
            ackPinOe  <= !ackActive && gpioOutDir[`HPSH_LINE_ACK]; // RULE10
        end
    end

endmodule

// ---- hpsh_map.vh ----
// Constants for the host port strobe handshake block.
// The file assumes that it is included by the bare name hpsh_map.vh.
// Notes on behaviour
// [RULE1] Strobe low, direction high: drive data lines
// [RULE2] Strobe low, direction low: data lines input
// [RULE3] Capture write data at strobe rising edge
// [RULE4] Host builds strobe from chip select, enable
// [RULE5] Service request is open drain, pulls low
// [RULE6] Acknowledge completes each requested DMA transfer
// [RULE7] Acknowledge also takes interrupt acknowledge cycle
// [RULE8] Strobe pin is GPIO when port unused
// [RULE9] Request pin is push-pull GPIO when deselected
// [RULE10] Acknowledge pin GPIO when deselected or programmed
// [RULE11] After reset all three pins GPIO inputs
// [RULE12] Data lines released while strobe stays high
// [RULE13] Register select accompanies each strobed access
// [RULE14] Synchronise strobe before using its rising edge
`ifndef HPSH_MAP_VH
`define HPSH_MAP_VH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define HPSH_DATA_W      8
`define HPSH_SEL_W       3
`define HPSH_WORD_W      11
`define HPSH_FIFO_DEPTH  16
`define HPSH_FIFO_AW     4

// ----------------------------------------------------------------
// Field positions of a buffered host write word
// ----------------------------------------------------------------
`define HPSH_WORD_DATA_LSB 0
`define HPSH_WORD_SEL_LSB  8

// ----------------------------------------------------------------
// GPIO line index for the three shared pins
// ----------------------------------------------------------------
`define HPSH_LINE_STROBE 0
`define HPSH_LINE_REQ    1
`define HPSH_LINE_ACK    2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HPSH_RST_BYTE  8'h00
`define HPSH_RST_LINES 3'h0

`endif

// ---- hpsh_fifo.v ----
// Buffer of host write words with a registered output stage.
// Assumes one clock and a synchronous, already released reset.
`timescale 1ns/10ps
module hpsh_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clock,    // System clock
    input  wire             rst_n,    // Released reset, active low
    input  wire             inValid,  // Write word offered
    output wire             inReady,  // Room for a word
    input  wire [WIDTH-1:0] inData,   // Write word
    output reg              outValid, // Head word valid
    input  wire             outReady, // Drain side takes word
    output reg  [WIDTH-1:0] outData   // Head word
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_reg;
    reg [AW-1:0]    rdPtr_reg;
    reg [AW:0]      count_reg;
    wire            doWrite;
    wire            doLoad;

    // Pointer advance with wrap
    function [AW-1:0] nextPtr;
        input [AW-1:0] ptr;
        begin
            if (ptr == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1})
                nextPtr = {AW{1'b0}};
            else
                nextPtr = ptr + {{(AW-1){1'b0}}, 1'b1};
        end
    endfunction

    // Full and load conditions; the output register counts toward the depth
    assign inReady = ((count_reg + {{AW{1'b0}}, outValid}) != DEPTH[AW:0]);
    assign doWrite = inValid && inReady;
    assign doLoad  = (count_reg != {(AW+1){1'b0}}) && (!outValid || outReady);

    // Storage array
    always @(posedge clock) begin
        if (doWrite)
            mem[wrPtr_reg] <= inData;
    end

    // Pointers, count and output register
    always @(posedge clock) begin
        if (!rst_n) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            outValid  <= 1'b0;
            outData   <= {WIDTH{1'b0}};
        end else begin
            if (doWrite)
                wrPtr_reg <= nextPtr(wrPtr_reg);
            if (doLoad) begin
                rdPtr_reg <= nextPtr(rdPtr_reg);
                outData   <= mem[rdPtr_reg];
                outValid  <= 1'b1;
            end else if (outReady) begin
                outValid  <= 1'b0;
            end
            if (doWrite && !doLoad)
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            else if (!doWrite && doLoad)
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
        end
    end

endmodule

// ---- hpsh_properties.sv ----
// Checker of the host port strobe handshake pin behaviour.
// Assumes it is bound into hpsh_top and sees only that module's ports.
`timescale 1ns/10ps
module hpsh_properties #(
    parameter DATA_W = 8
) (
    input wire logic              clock,          // System clock
    input wire logic              arst_n,         // Reset, active low
    input wire logic              strobePinIn,    // Strobe pin level
    input wire logic              strobePinOut,   // Strobe drive value
    input wire logic              strobePinOe,    // Strobe drive enable
    input wire logic              host_direction, // High: host reads
    input wire logic [DATA_W-1:0] dataPinOe,      // Data drive enable
    input wire logic              reqPinOut,      // Request drive value
    input wire logic              reqPinOe,       // Request drive enable
    input wire logic              ackPinIn,       // Acknowledge level
    input wire logic              ackPinOut,      // Acknowledge drive value
    input wire logic              ackPinOe,       // Acknowledge drive enable
    input wire logic              hostPortSelect, // Host function on
    input wire logic              ackAsGpio,      // Ack pin kept GPIO
    input wire logic [2:0]        gpioOutValue,   // GPIO values
    input wire logic [2:0]        gpioOutDir,     // GPIO directions
    input wire logic              serviceReq,     // Core wants service
    input wire logic              wrValid         // Buffered write valid
);
    // ----------------------------------------------------------------
    // Pin relations
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    read_drive_a: assert property ((hostPortSelect && !strobePinIn && host_direction)[*4] |=> &dataPinOe)
        else $error("data bus idle during host read");
    write_input_a: assert property ((!strobePinIn && !host_direction && ackPinIn)[*4] |=> !(|dataPinOe))
        else $error("data bus driven during host write");
    write_push_a: assert property (($rose(strobePinIn) && hostPortSelect && !host_direction && !wrValid)
        |-> !wrValid[*2] ##[1:6] wrValid) else $error("host write not buffered in time");
    req_open_a: assert property (hostPortSelect[*3] |-> !(reqPinOe && reqPinOut))
        else $error("request driven high in host mode");
    req_release_a: assert property ((hostPortSelect && !serviceReq)[*3] |=> !reqPinOe)
        else $error("request pulled without service");
    strobe_gpio_a: assert property ((!hostPortSelect && gpioOutDir[0] && !gpioOutValue[0])[*3]
        |=> strobePinOe && !strobePinOut) else $error("strobe line not driven as port line");
    req_pushpull_a: assert property ((!hostPortSelect && gpioOutDir[1] && gpioOutValue[1])[*3]
        |=> reqPinOe && reqPinOut) else $error("request line not push pull");
    ack_gpio_a: assert property ((ackAsGpio && gpioOutDir[2] && !gpioOutValue[2])[*3]
        |=> ackPinOe && !ackPinOut) else $error("acknowledge line not driven as port line");
    reset_idle_a: assert property ($rose(arst_n) |-> (!strobePinOe && !reqPinOe && !ackPinOe)[*2])
        else $error("pin driven right after reset");
    idle_release_a: assert property ((strobePinIn && ackPinIn)[*4] |=> !(|dataPinOe))
        else $error("data bus driven while strobe idle");
endmodule

bind hpsh_top hpsh_properties #(.DATA_W(DATA_W)) u_props (
    .clock(clock), .arst_n(arst_n), .strobePinIn(strobePinIn), .strobePinOut(strobePinOut),
    .strobePinOe(strobePinOe), .host_direction(host_direction), .dataPinOe(dataPinOe),
    .reqPinOut(reqPinOut), .reqPinOe(reqPinOe), .ackPinIn(ackPinIn), .ackPinOut(ackPinOut),
    .ackPinOe(ackPinOe), .hostPortSelect(hostPortSelect), .ackAsGpio(ackAsGpio),
    .gpioOutValue(gpioOutValue), .gpioOutDir(gpioOutDir), .serviceReq(serviceReq), .wrValid(wrValid)
);

// ---- hpsh_host.sv ----
// Host processor model on the far side of the strobe handshake.
// Assumes the bench calls its tasks; it changes pins on falling edges.
`timescale 1ns/10ps
module hpsh_host (
    input  wire logic       clock,           // System clock
    input  wire logic       strobePinOe,     // Device drives strobe
    input  wire logic       strobePinOut,    // Device strobe value
    input  wire logic [7:0] dataPinOe,       // Device data enable
    input  wire logic [7:0] dataPinOut,      // Device data value
    input  wire logic       reqPinOe,        // Device request enable
    input  wire logic       reqPinOut,       // Device request value
    input  wire logic       ackPinOe,        // Device ack enable
    input  wire logic       ackPinOut,       // Device ack value
    output wire logic       strobePinIn,     // Resolved strobe
    output logic            host_direction,  // High: host reads
    output logic [2:0]      host_reg_select, // Register select
    output wire logic [7:0] dataPinIn,       // Resolved data bus
    output wire logic       reqPinIn,        // Resolved request
    output wire logic       ackPinIn         // Resolved ack
);
    logic       strobeN = 1'b1;
    logic       ackN = 1'b1;
    logic       dataDrive = 1'b0;
    logic [7:0] dataVal = 8'h00;

    // Pin resolution; request has a pull-up, idle data shows inverse
    assign strobePinIn = strobePinOe ? strobePinOut : strobeN;
    assign ackPinIn = ackPinOe ? ackPinOut : ackN;
    assign reqPinIn = reqPinOe ? reqPinOut : 1'b1;
    assign dataPinIn = dataPinOe[0] ? dataPinOut : (dataDrive ? dataVal : ~dataVal);

    initial begin
        host_direction = 1'b0;
        host_reg_select = 3'h0;
    end

    // Write: strobe stands for decoded select and enable together
    task automatic hostWrite(input logic [2:0] sel, input logic [7:0] val, input int hold);
        @(negedge clock);
        host_direction = 1'b0;
        host_reg_select = sel;
        dataVal = val;
        dataDrive = 1'b1;
        @(negedge clock);
        strobeN = 1'b0;
        repeat (hold) @(negedge clock);
        strobeN = 1'b1;
        repeat (3) @(negedge clock);
        dataDrive = 1'b0;
    endtask

    // Read: bus sampled just before the strobe is released
    task automatic hostRead(input logic [2:0] sel, input int hold, output logic [7:0] val);
        @(negedge clock);
        host_direction = 1'b1;
        host_reg_select = sel;
        @(negedge clock);
        strobeN = 1'b0;
        repeat (hold) @(negedge clock);
        val = dataPinIn;
        strobeN = 1'b1;
        repeat (4) @(negedge clock);
        host_direction = 1'b0;
    endtask

    // Acknowledge cycle, for DMA or interrupt acknowledge alike
    task automatic hostAck(input int hold, output logic [7:0] val);
        @(negedge clock);
        ackN = 1'b0;
        repeat (hold) @(negedge clock);
        val = dataPinIn;
        ackN = 1'b1;
        repeat (4) @(negedge clock);
    endtask
endmodule

// ---- host_port_strobe_handshake_test.sv ----
// Self-checking bench of the host port strobe handshake.
// Assumes hpsh_top, the host model and the bound checker are compiled.
`timescale 1ns/10ps
module host_port_strobe_handshake_test;
    logic clock = 1'b0, arst_n = 1'b0, hostPortSelect = 1'b0, ackAsGpio = 1'b0;
    logic serviceReq = 1'b0, irqMode = 1'b0, wrReady = 1'b0;
    logic [2:0] gpioOutValue = 3'h0, gpioOutDir = 3'h0;
    logic [7:0] coreReadData = 8'h00, coreVector = 8'h00;
    logic strobePinIn, strobePinOut, strobePinOe, host_direction, reqPinIn, reqPinOut, reqPinOe;
    logic ackPinIn, ackPinOut, ackPinOe, readDonePulse, dmaAckPulse, intAckPulse, writeOverflow, wrValid;
    logic [2:0] host_reg_select, gpioInValue, readSelect, wrSelect;
    logic [7:0] dataPinIn, dataPinOut, dataPinOe, wrData;
    int fail_count = 0, check_count = 0, doneCnt = 0, dmaCnt = 0, intCnt = 0, ovfCnt = 0;

    always #50 clock = ~clock;

    hpsh_top u_dut (.clock(clock), .arst_n(arst_n), .strobePinIn(strobePinIn), .strobePinOut(strobePinOut),
        .strobePinOe(strobePinOe), .host_direction(host_direction), .host_reg_select(host_reg_select),
        .dataPinIn(dataPinIn), .dataPinOut(dataPinOut), .dataPinOe(dataPinOe), .reqPinIn(reqPinIn),
        .reqPinOut(reqPinOut), .reqPinOe(reqPinOe), .ackPinIn(ackPinIn), .ackPinOut(ackPinOut),
        .ackPinOe(ackPinOe), .hostPortSelect(hostPortSelect), .ackAsGpio(ackAsGpio),
        .gpioOutValue(gpioOutValue), .gpioOutDir(gpioOutDir), .gpioInValue(gpioInValue),
        .serviceReq(serviceReq), .irqMode(irqMode), .coreReadData(coreReadData), .coreVector(coreVector),
        .readDonePulse(readDonePulse), .readSelect(readSelect), .dmaAckPulse(dmaAckPulse),
        .intAckPulse(intAckPulse), .writeOverflow(writeOverflow), .wrValid(wrValid), .wrReady(wrReady),
        .wrData(wrData), .wrSelect(wrSelect));
    hpsh_host host (.clock(clock), .strobePinOe(strobePinOe), .strobePinOut(strobePinOut),
        .dataPinOe(dataPinOe), .dataPinOut(dataPinOut), .reqPinOe(reqPinOe), .reqPinOut(reqPinOut),
        .ackPinOe(ackPinOe), .ackPinOut(ackPinOut), .strobePinIn(strobePinIn),
        .host_direction(host_direction), .host_reg_select(host_reg_select), .dataPinIn(dataPinIn),
        .reqPinIn(reqPinIn), .ackPinIn(ackPinIn));

    // Pulse counters
    always @(posedge clock) begin
        if (readDonePulse === 1'b1) doneCnt++;
        if (dmaAckPulse === 1'b1) dmaCnt++;
        if (intAckPulse === 1'b1) intCnt++;
        if (writeOverflow === 1'b1) ovfCnt++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Port lines while deselected, then ack kept as port line
    task automatic testGpio();
        gpioOutDir = 3'b111;
        gpioOutValue = 3'b010;
        repeat (6) @(negedge clock);
        check({strobePinOe, strobePinOut}, 16'h2);
        check({reqPinOe, reqPinOut}, 16'h3);
        check(gpioInValue, 16'h2);
        gpioOutDir = 3'b000;
        repeat (4) @(negedge clock);
        hostPortSelect = 1'b1;
        ackAsGpio = 1'b1;
        gpioOutDir = 3'b100;
        repeat (4) @(negedge clock);
        check({ackPinOe, ackPinOut, reqPinOe}, 16'h4);
        ackAsGpio = 1'b0;
        gpioOutDir = 3'b000;
        repeat (4) @(negedge clock);
    endtask

    task automatic testRead();
        logic [7:0] v;
        coreReadData = 8'ha5;
        host.hostRead(3'h5, 6, v);
        check(v, 16'ha5);
        check(readSelect, 16'h5);
        check(doneCnt[7:0], 16'h1);
        check(dataPinOe, 16'h0);
    endtask

    // Ack refused without request, then interrupt and DMA forms
    task automatic testAck();
        logic [7:0] v;
        coreVector = 8'h6c;
        coreReadData = 8'h93;
        host.hostAck(5, v);
        check({dmaCnt[7:0], intCnt[7:0]}, 16'h0);
        serviceReq = 1'b1;
        irqMode = 1'b1;
        repeat (4) @(negedge clock);
        check({reqPinOe, reqPinOut, reqPinIn}, 16'h4);
        host.hostAck(5, v);
        check(v, 16'h6c);
        check(intCnt[7:0], 16'h1);
        irqMode = 1'b0;
        host.hostAck(5, v);
        check(v, 16'h93);
        check(dmaCnt[7:0], 16'h1);
        serviceReq = 1'b0;
    endtask

    // Fill buffer past full with core stalled, then drain in order
    task automatic testFill();
        int i;
        int n;
        serviceReq = 1'b1;
        for (i = 0; i < 17; i++) host.hostWrite(i[2:0], 8'h30 + i[7:0], 4);
        repeat (3) @(negedge clock);
        check(ovfCnt[7:0], 16'h1);
        check(reqPinOe, 16'h0);
        for (i = 0; i < 16; i++) begin
            n = 0;
            while (wrValid !== 1'b1 && n < 8) begin
                @(negedge clock);
                n++;
            end
            check({wrValid, wrSelect, wrData}, {1'b1, i[2:0], 8'h30 + i[7:0]});
            wrReady = 1'b1;
            @(negedge clock);
            wrReady = 1'b0;
        end
        repeat (4) @(negedge clock);
        check(wrValid, 16'h0);
        serviceReq = 1'b0;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock);
        arst_n = 1'b1;
        repeat (3) @(negedge clock);
        check({strobePinOe, reqPinOe, ackPinOe, dataPinOe}, 16'h0);
        testGpio();
        testRead();
        testAck();
        testFill();
        results();
    end

    // Watchdog
    initial begin
        #(3000 * 100);
        fail_count++;
        results();
    end
endmodule
